// [core/pfio_exec.sv]
// program-flow and port transfer execution unit with command fifo
`timescale 1ns/100ps

module pfio_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  generate
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  wire           push_w = in_valid_i && in_ready_o;
  wire           pop_w  = out_valid_o && out_ready_i;

  assign cnt_nxt    = cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
  assign out_data_o = mem_r[rp_r];

  // ready and valid are registered from the next count so both stay honest
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wp_r        <= '0;
      rp_r        <= '0;
      cnt_r       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push_w) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop_w) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r       <= cnt_nxt;
      in_ready_o  <= cnt_nxt != (AW+1)'(D);
      out_valid_o <= cnt_nxt != '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push_w) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule

module pfio_exec
  import pfio_pkg::*;
#(
  parameter int DEPTH = CMD_DEPTH
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // command stream from the sequencer
  input  wire logic        cmd_valid_i,
  input  wire pfio_cmd_t   cmd_i,
  output logic             cmd_ready_o,
  // system context
  input  wire logic        irq_pend_i,
  input  wire logic [15:0] vec_base_i,
  // stack and operand memory
  output pfio_mreq_t       mem_req_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  // port bus, external and on-chip
  output pfio_preq_t       port_req_o,
  input  wire logic        port_ack_i,
  input  wire logic [15:0] port_rdata_i,
  // completion
  output logic             done_o,
  output pfio_res_t        res_o
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_DECIDE, ST_PUSH1, ST_PUSH2, ST_POP, ST_VEC1, ST_VEC2,
    ST_PIO, ST_MWR, ST_MRD, ST_DONE
  } pfio_st_t;

  function automatic logic cond_ok(input logic en, input logic [2:0] cc,
                                   input logic [7:0] f);
    logic r;
    r = 1'b1;
    if (en) begin
      case (cc)
        CC_NZ:   r = !f[FL_Z];
        CC_Z:    r = f[FL_Z];
        CC_NC:   r = !f[FL_C];
        CC_C:    r = f[FL_C];
        CC_PO:   r = !f[FL_PV];
        CC_PE:   r = f[FL_PV];
        CC_P:    r = !f[FL_S];
        CC_M:    r = f[FL_S];
        default: r = 1'b1;
      endcase
    end
    return r;
  endfunction

  function automatic logic [7:0] in_flags(input logic [7:0] d,
                                          input logic [7:0] f);
    logic [7:0] r;
    r        = f;
    r[FL_S]  = d[7];
    r[FL_Z]  = d == 8'h00;
    r[FL_H]  = 1'b0;
    r[FL_PV] = ~^d;
    r[FL_N]  = 1'b0;
    return r;
  endfunction

  function automatic pfio_mreq_t mreq(input logic wr, input logic wd,
                                      input logic [15:0] a,
                                      input logic [15:0] d);
    pfio_mreq_t r;
    r.valid = 1'b1;
    r.write = wr;
    r.word  = wd;
    r.addr  = a;
    r.wdata = d;
    return r;
  endfunction

  pfio_st_t   st_r;
  pfio_st_t   st_nxt;
  pfio_cmd_t  cmd_r;
  pfio_cmd_t  cmd_nxt;
  pfio_res_t  res_nxt;
  pfio_mreq_t mreq_nxt;
  pfio_preq_t preq_nxt;
  logic [15:0] dat_r;
  logic [15:0] dat_nxt;
  logic [15:0] tgt_r;
  logic [15:0] tgt_nxt;
  logic        done_nxt;

  logic       fifo_valid;
  pfio_cmd_t  fifo_data;
  wire        fifo_take = st_r == ST_IDLE;

  // the fifo buffers commands while a port or stack cycle is pending and stalls the sequencer only when DEPTH entries are held
  pfio_fifo #(
    .W ($bits(pfio_cmd_t)),
    .D (DEPTH)
  ) u_cmd_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (cmd_valid_i),
    .in_data_i   (cmd_i),
    .in_ready_o  (cmd_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_take)
  );

  // decode of the held command
  wire [15:0] seq_pc  = cmd_r.pc + 16'(cmd_r.ilen);
  wire [15:0] jr_tgt  = cmd_r.pc + SJ_LEN +
                        {{8{cmd_r.operand[7]}}, cmd_r.operand[7:0]};
  wire [15:0] abs_tgt = (cmd_r.amode == AM_IR) ? cmd_r.ir_val :
                        (cmd_r.amode == AM_RA) ? seq_pc + cmd_r.operand :
                        cmd_r.operand;
  wire        flag_ok = cond_ok(cmd_r.cond_en, cmd_r.cc, cmd_r.flags);
  wire        taken   = (cmd_r.op == OP_ALTF)   ? cmd_r.alt_file :
                        (cmd_r.op == OP_ALTACC) ? cmd_r.alt_acc : flag_ok;
  wire [7:0]  loop_b  = cmd_r.b - 8'h01;
  wire        is_port = cmd_r.op inside {OP_IN, OP_INA, OP_PTEST, OP_OUT,
                        OP_OUTA, OP_WIN, OP_WOUT, OP_BLKIN, OP_BLKOUT};
  wire        priv_no = is_port && cmd_r.user_mode && cmd_r.io_inhibit;
  wire        is_blk  = cmd_r.op inside {OP_BLKIN, OP_BLKOUT};
  wire        imm_prt = cmd_r.op inside {OP_INA, OP_OUTA};
  wire        is_wr   = cmd_r.op inside {OP_OUT, OP_OUTA, OP_WOUT, OP_BLKOUT};
  wire        is_wd   = cmd_r.op inside {OP_WIN, OP_WOUT} ||
                        (is_blk && cmd_r.word);
  // block forms hold one port address for the whole string
  wire [15:0] port16  = imm_prt ? {cmd_r.acc, cmd_r.operand[7:0]} :
                        is_blk ? {8'h00, cmd_r.c} :
                        {cmd_r.b, cmd_r.c};
  wire        on_chip = cmd_r.io_page == PAGE_CHIP_HI ||
                        cmd_r.io_page == PAGE_CHIP_LO;
  wire [15:0] out_dat = (cmd_r.op == OP_WOUT) ?
                        {cmd_r.hl[7:0], cmd_r.hl[15:8]} :
                        (cmd_r.op == OP_OUTA) ? {8'h00, cmd_r.acc} :
                        (cmd_r.op == OP_OUT) ? {8'h00, cmd_r.src} :
                        cmd_r.word ? dat_r : {8'h00, dat_r[7:0]};
  wire [15:0] step    = cmd_r.word ? WORD_STEP : BYTE_STEP;
  wire [15:0] hl_step = cmd_r.dec ? res_o.hl - step : res_o.hl + step;
  wire [7:0]  blk_b   = res_o.b - 8'h01;
  wire        elem_end = (st_r == ST_MWR && mem_ack_i &&
                          cmd_r.op == OP_BLKIN) ||
                         (st_r == ST_PIO && port_ack_i &&
                          cmd_r.op == OP_BLKOUT);
  wire [15:0] push_sp = res_o.sp - STACK_STEP;

  // port request: page register on the upper lines, on-chip pages
  // never raise the external strobe, and every word size is accepted
  pfio_preq_t port_go;
  always_comb begin
    port_go.ext_valid  = !on_chip;
    port_go.chip_valid = on_chip;
    port_go.write      = is_wr;
    port_go.word       = is_wd;
    port_go.addr       = {cmd_r.io_page, port16};
    port_go.wdata      = out_dat;
  end

  always_comb begin
    st_nxt   = st_r;
    cmd_nxt  = cmd_r;
    res_nxt  = res_o;
    mreq_nxt = mem_req_o;
    preq_nxt = port_req_o;
    dat_nxt  = dat_r;
    tgt_nxt  = tgt_r;
    done_nxt = 1'b0;
    if (mem_ack_i) begin
      mreq_nxt.valid = 1'b0;
    end
    if (port_ack_i) begin
      preq_nxt.ext_valid  = 1'b0;
      preq_nxt.chip_valid = 1'b0;
    end
    case (st_r)
      ST_IDLE: begin
        if (fifo_valid) begin
          cmd_nxt = fifo_data;
          st_nxt  = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        // start from the incoming state; only listed fields change
        res_nxt          = '0;
        res_nxt.pc       = seq_pc;
        res_nxt.sp       = cmd_r.sp;
        res_nxt.flags    = cmd_r.flags;
        res_nxt.hl       = cmd_r.hl;
        res_nxt.b        = cmd_r.b;
        res_nxt.msr      = cmd_r.msr;
        res_nxt.reg_sel  = cmd_r.dst_sel;
        st_nxt           = ST_DONE;
        if (priv_no) begin
          res_nxt.pc   = cmd_r.pc;
          res_nxt.trap = 1'b1;
        end else begin
          case (cmd_r.op)
            OP_JUMP: begin
              if (taken) begin
                res_nxt.pc = abs_tgt;
              end
            end
            OP_JREL, OP_ALTF, OP_ALTACC: begin
              if (taken) begin
                res_nxt.pc = jr_tgt;
              end
            end
            OP_LOOP: begin
              res_nxt.b    = loop_b;
              res_nxt.b_we = 1'b1;
              if (loop_b != 8'h00) begin
                res_nxt.pc = jr_tgt;
              end
            end
            OP_CALL: begin
              if (taken) begin
                tgt_nxt    = abs_tgt;
                res_nxt.sp = cmd_r.sp - STACK_STEP;
                mreq_nxt   = mreq(1'b1, 1'b1, cmd_r.sp - STACK_STEP,
                                  seq_pc);
                st_nxt     = ST_PUSH1;
              end
            end
            OP_RETURN: begin
              if (taken) begin
                mreq_nxt = mreq(1'b0, 1'b1, cmd_r.sp, 16'h0000);
                st_nxt   = ST_POP;
              end
            end
            OP_OSCALL: begin
              res_nxt.sp = cmd_r.sp - STACK_STEP;
              mreq_nxt   = mreq(1'b1, 1'b1, cmd_r.sp - STACK_STEP,
                                seq_pc);
              st_nxt     = ST_PUSH1;
            end
            OP_CSET: begin
              res_nxt.flags[FL_C] = 1'b1;
              res_nxt.flags[FL_N] = 1'b0;
              res_nxt.flags_we    = 1'b1;
            end
            OP_CCPL: begin
              res_nxt.flags[FL_C] = !cmd_r.flags[FL_C];
              res_nxt.flags[FL_N] = 1'b0;
              res_nxt.flags_we    = 1'b1;
            end
            OP_BLKOUT: begin
              mreq_nxt = mreq(1'b0, cmd_r.word, cmd_r.hl, 16'h0000);
              st_nxt   = ST_MRD;
            end
            OP_IN, OP_INA, OP_PTEST, OP_OUT, OP_OUTA, OP_WIN, OP_WOUT,
            OP_BLKIN: begin
              preq_nxt = port_go;
              st_nxt   = ST_PIO;
            end
            default: st_nxt = ST_DONE;
          endcase
        end
      end
      ST_PUSH1: begin
        if (mem_ack_i) begin
          if (cmd_r.op == OP_OSCALL) begin
            res_nxt.sp = push_sp;
            mreq_nxt   = mreq(1'b1, 1'b1, push_sp, cmd_r.msr);
            st_nxt     = ST_PUSH2;
          end else begin
            res_nxt.pc = tgt_r;
            st_nxt     = ST_DONE;
          end
        end
      end
      ST_PUSH2: begin
        if (mem_ack_i) begin
          mreq_nxt = mreq(1'b0, 1'b1, vec_base_i + OS_MSR_OFS, 16'h0000);
          st_nxt   = ST_VEC1;
        end
      end
      ST_VEC1: begin
        if (mem_ack_i) begin
          res_nxt.msr    = mem_rdata_i;
          res_nxt.msr_we = 1'b1;
          mreq_nxt = mreq(1'b0, 1'b1, vec_base_i + OS_PC_OFS, 16'h0000);
          st_nxt   = ST_VEC2;
        end
      end
      ST_VEC2: begin
        if (mem_ack_i) begin
          res_nxt.pc = mem_rdata_i;
          st_nxt     = ST_DONE;
        end
      end
      ST_POP: begin
        if (mem_ack_i) begin
          res_nxt.pc = mem_rdata_i;
          res_nxt.sp = cmd_r.sp + STACK_STEP;
          st_nxt     = ST_DONE;
        end
      end
      ST_PIO: begin
        if (port_ack_i) begin
          st_nxt = ST_DONE;
          case (cmd_r.op)
            OP_IN: begin
              res_nxt.flags    = in_flags(port_rdata_i[7:0],
                                          cmd_r.flags);
              res_nxt.flags_we = 1'b1;
              if (cmd_r.dst_mem) begin
                mreq_nxt = mreq(1'b1, 1'b0, cmd_r.mem_addr,
                                {8'h00, port_rdata_i[7:0]});
                st_nxt   = ST_MWR;
              end else begin
                res_nxt.reg_we   = 1'b1;
                res_nxt.reg_data = port_rdata_i[7:0];
              end
            end
            OP_INA: begin
              res_nxt.reg_we   = 1'b1;
              res_nxt.reg_sel  = REG_SEL_A;
              res_nxt.reg_data = port_rdata_i[7:0];
            end
            OP_PTEST: begin
              res_nxt.flags    = in_flags(port_rdata_i[7:0],
                                          cmd_r.flags);
              res_nxt.flags_we = 1'b1;
            end
            OP_WIN: begin
              res_nxt.hl    = {port_rdata_i[7:0], port_rdata_i[15:8]};
              res_nxt.hl_we = 1'b1;
            end
            OP_BLKIN: begin
              mreq_nxt = mreq(1'b1, cmd_r.word, res_o.hl,
                              cmd_r.word ? port_rdata_i :
                              {8'h00, port_rdata_i[7:0]});
              st_nxt   = ST_MWR;
            end
            default: st_nxt = ST_DONE;
          endcase
        end
      end
      ST_MWR: begin
        if (mem_ack_i) begin
          st_nxt = ST_DONE;
        end
      end
      ST_MRD: begin
        if (mem_ack_i) begin
          dat_nxt  = mem_rdata_i;
          st_nxt   = ST_PIO;
          preq_nxt = port_go;
          preq_nxt.wdata = cmd_r.word ? mem_rdata_i :
                           {8'h00, mem_rdata_i[7:0]};
        end
      end
      ST_DONE: begin
        done_nxt = 1'b1;
        st_nxt   = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    // one block element finished: step memory address, count down
    if (elem_end) begin
      res_nxt.hl          = hl_step;
      res_nxt.hl_we       = 1'b1;
      res_nxt.b           = blk_b;
      res_nxt.b_we        = 1'b1;
      res_nxt.flags[FL_Z] = blk_b == 8'h00;
      res_nxt.flags_we    = 1'b1;
      st_nxt              = ST_DONE;
      if (cmd_r.rpt && blk_b != 8'h00) begin
        if (irq_pend_i) begin
          // pc left on this instruction so it restarts after service
          res_nxt.pc     = cmd_r.pc;
          res_nxt.resume = 1'b1;
        end else if (cmd_r.op == OP_BLKIN) begin
          preq_nxt = port_go;
          st_nxt   = ST_PIO;
        end else begin
          mreq_nxt = mreq(1'b0, cmd_r.word, hl_step, 16'h0000);
          st_nxt   = ST_MRD;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r       <= ST_IDLE;
      cmd_r      <= '0;
      res_o      <= '0;
      mem_req_o  <= '0;
      port_req_o <= '0;
      dat_r      <= 16'h0000;
      tgt_r      <= 16'h0000;
      done_o     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cmd_r      <= cmd_nxt;
      res_o      <= res_nxt;
      mem_req_o  <= mreq_nxt;
      port_req_o <= preq_nxt;
      dat_r      <= dat_nxt;
      tgt_r      <= tgt_nxt;
      done_o     <= done_nxt;
    end
  end

endmodule

// [core/pfio_pkg.sv]
// shared types and constants for the program-flow and port transfer unit
package pfio_pkg;

  // operation classes handed over by the instruction sequencer
  typedef enum logic [4:0] {
    OP_JUMP, OP_JREL, OP_ALTF, OP_ALTACC, OP_LOOP, OP_CALL, OP_RETURN,
    OP_OSCALL, OP_CSET, OP_CCPL, OP_IN, OP_INA, OP_PTEST, OP_OUT, OP_OUTA,
    OP_WIN, OP_WOUT, OP_BLKIN, OP_BLKOUT
  } pfio_op_t;

  // operand addressing for absolute jump and call
  typedef enum logic [1:0] {AM_DA, AM_IR, AM_RA} pfio_am_t;

  // flag byte layout
  localparam int FL_S  = 7;
  localparam int FL_Z  = 6;
  localparam int FL_H  = 4;
  localparam int FL_PV = 2;
  localparam int FL_N  = 1;
  localparam int FL_C  = 0;

  // condition code encodings
  localparam logic [2:0] CC_NZ = 3'h0;
  localparam logic [2:0] CC_Z  = 3'h1;
  localparam logic [2:0] CC_NC = 3'h2;
  localparam logic [2:0] CC_C  = 3'h3;
  localparam logic [2:0] CC_PO = 3'h4;
  localparam logic [2:0] CC_PE = 3'h5;
  localparam logic [2:0] CC_P  = 3'h6;
  localparam logic [2:0] CC_M  = 3'h7;

  // port pages kept on chip
  localparam logic [7:0]  PAGE_CHIP_HI = 8'hff;
  localparam logic [7:0]  PAGE_CHIP_LO = 8'hfe;
  // os call vector layout: status word, then program counter
  localparam logic [15:0] OS_MSR_OFS   = 16'h0000;
  localparam logic [15:0] OS_PC_OFS    = 16'h0002;
  // stack and address steps
  localparam logic [15:0] STACK_STEP   = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] SJ_LEN       = 16'h0002;
  localparam int          CMD_DEPTH    = 8;

  typedef struct packed {
    pfio_op_t    op;
    logic        cond_en;
    logic [2:0]  cc;
    pfio_am_t    amode;
    logic [2:0]  ilen;
    logic [15:0] pc;
    logic [15:0] operand;
    logic [15:0] ir_val;
    logic [15:0] sp;
    logic [7:0]  flags;
    logic [15:0] msr;
    logic [7:0]  acc;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [15:0] hl;
    logic [7:0]  src;
    logic [2:0]  dst_sel;
    logic        dst_mem;
    logic [15:0] mem_addr;
    logic        rpt;
    logic        dec;
    logic        word;
    logic        alt_file;
    logic        alt_acc;
    logic        user_mode;
    logic        io_inhibit;
    logic [7:0]  io_page;
  } pfio_cmd_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  flags;
    logic        flags_we;
    logic [15:0] hl;
    logic        hl_we;
    logic [7:0]  b;
    logic        b_we;
    logic        reg_we;
    logic [2:0]  reg_sel;
    logic [7:0]  reg_data;
    logic [15:0] msr;
    logic        msr_we;
    logic        trap;
    logic        resume;
  } pfio_res_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pfio_mreq_t;

  typedef struct packed {
    logic        ext_valid;
    logic        chip_valid;
    logic        write;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pfio_preq_t;

  localparam logic [2:0] REG_SEL_A = 3'h7;

endpackage

// [dv/pfio_bus_model.sv]
// far-side model: stack memory and port peripherals
`timescale 1ns/100ps
module pfio_bus_model
  import pfio_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       slow_i,
  input  wire pfio_mreq_t mem_req_i,
  output logic            mem_ack_o,
  output logic [15:0]     mem_rdata_o,
  input  wire pfio_preq_t port_req_i,
  output logic            port_ack_o,
  output logic [15:0]     port_rdata_o
);
  logic [15:0] mem_r [256];
  logic [1:0]  mc_r;
  logic [1:0]  pc_r;
  wire mgo = mem_req_i.valid && !mem_ack_o;
  wire pgo = (port_req_i.ext_valid || port_req_i.chip_valid) && !port_ack_o;
  initial begin
    mem_ack_o = 1'b0;
    port_ack_o = 1'b0;
    mem_rdata_o = 16'h0000;
    port_rdata_o = 16'h0000;
  end
  // released data lines toggle so a stale value never passes
  always @(posedge sys_clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    mc_r <= mgo ? mc_r + 2'h1 : 2'h0;
    if (mgo && mc_r >= {slow_i, slow_i}) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem_r[mem_req_i.addr[8:1]];
      if (mem_req_i.write)
        mem_r[mem_req_i.addr[8:1]] <= mem_req_i.wdata;
    end
  end
  // peripherals answer on all sixteen lines; word reads served too
  always @(posedge sys_clk_i) begin
    port_ack_o <= 1'b0;
    port_rdata_o <= ~port_rdata_o;
    pc_r <= pgo ? pc_r + 2'h1 : 2'h0;
    if (pgo && pc_r >= {slow_i, slow_i}) begin
      port_ack_o <= 1'b1;
      port_rdata_o <= port_req_i.addr[15:0] ^ 16'ha5c3;
    end
  end
endmodule

// [dv/pfio_exec_properties.sv]
// port checker for the execution unit
`timescale 1ns/100ps
module pfio_exec_chk
  import pfio_pkg::*;
#(parameter int DEPTH = CMD_DEPTH)
(
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       cmd_ready_o,
  input wire pfio_mreq_t mem_req_o,
  input wire logic       mem_ack_i,
  input wire pfio_preq_t port_req_o,
  input wire logic       port_ack_i,
  input wire logic       done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire pv = port_req_o.ext_valid | port_req_o.chip_valid;
  ext_page_a: assert property (
    port_req_o.ext_valid |-> port_req_o.addr[23:17] != 7'h7f)
    else $error("chip page on external bus");
  chip_page_a: assert property (
    port_req_o.chip_valid |-> port_req_o.addr[23:17] == 7'h7f)
    else $error("external page kept on chip");
  byte_low_a: assert property (
    pv && port_req_o.write && !port_req_o.word |->
    port_req_o.wdata[15:8] == 8'h00) else $error("byte on upper lines");
  port_hold_a: assert property (
    pv && !port_ack_i |=> $stable(port_req_o)) else $error("port req moved");
  mem_hold_a: assert property (
    mem_req_o.valid && !mem_ack_i |=> $stable(mem_req_o))
    else $error("mem req moved");
  port_drop_a: assert property (
    port_ack_i |=> !pv) else $error("port req held after ack");
  mem_drop_a: assert property (
    mem_ack_i |=> !(mem_req_o.valid && $stable(mem_req_o)))
    else $error("mem req repeated after ack");
  one_bus_a: assert property (
    !(mem_req_o.valid && pv)) else $error("two buses at once");
  done_pulse_a: assert property (
    done_o |=> !done_o ##1 !done_o) else $error("done too long");
  reset_idle_a: assert property ($rose(rst_n_i) |->
    cmd_ready_o && !done_o && !mem_req_o.valid && !pv)
    else $error("not idle after reset");
  cover property (port_req_o.chip_valid && port_ack_i);
  cover property (mem_req_o.write && mem_ack_i);
  cover property (port_req_o.ext_valid && port_req_o.word);
endmodule

// [dv/testbench.sv]
// self-checking bench for the execution unit
`timescale 1ns/100ps
module testbench;
  import pfio_pkg::*;
  logic        sys_clk_i, rst_n_i, cmd_valid_i, slow, mack, pack, irq;
  logic        cmd_ready_o, done_o;
  logic [15:0] mrd, prd;
  pfio_cmd_t   cmd_i, c;
  pfio_mreq_t  mreq;
  pfio_preq_t  preq, last_p;
  pfio_res_t   r;
  int          num_errors, check_count, n_ext, n_ack, k, j;
  pfio_exec #(.DEPTH(8)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .irq_pend_i(irq), .vec_base_i(16'h0100), .mem_req_o(mreq),
    .mem_ack_i(mack), .mem_rdata_i(mrd), .port_req_o(preq),
    .port_ack_i(pack), .port_rdata_i(prd), .done_o(done_o), .res_o(r));
  pfio_bus_model m (.sys_clk_i(sys_clk_i), .slow_i(slow),
    .mem_req_i(mreq), .mem_ack_o(mack), .mem_rdata_o(mrd),
    .port_req_i(preq), .port_ack_o(pack), .port_rdata_o(prd));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (pack) begin
    last_p <= preq;
    n_ack <= n_ack + 1;
    n_ext <= n_ext + int'(preq.ext_valid);
  end
  task automatic chk(input string n, input logic [23:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic run();
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    for (j = 0; j < 200 && done_o !== 1'b1; j++)
      @(posedge sys_clk_i);
    if (j == 200) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_flow();
    c = '0;
    c.op = OP_JUMP;
    c.pc = 16'h0100;
    c.ilen = 3'h3;
    c.operand = 16'h1234;
    c.cond_en = 1'b1;
    c.cc = CC_Z;
    run();
    chk("jump miss", 24'h000103, r.pc);
    c.flags = 8'h40;
    run();
    chk("jump take", 24'h001234, r.pc);
    chk("jump flags", 24'h0, r.flags_we);
    c.op = OP_JREL;
    c.operand = 16'h0080;
    run();
    chk("short back", 24'h000082, r.pc);
    c.op = OP_LOOP;
    c.cond_en = 1'b0;
    c.b = 8'h01;
    run();
    chk("loop b", 24'h000100, {r.b_we, r.b});
    c.b = 8'h03;
    run();
    chk("loop take", 24'h020082, {r.b, r.pc});
    c.op = OP_ALTF;
    run();
    chk("alt miss", 24'h000103, r.pc);
    c.alt_file = 1'b1;
    run();
    chk("alt take", 24'h000082, r.pc);
    c.op = OP_CCPL;
    c.flags = 8'h43;
    run();
    chk("carry flip", 24'h000140, {r.flags_we, r.flags});
    $display("flow test done");
  endtask
  task automatic t_stack();
    c = '0;
    c.op = OP_CALL;
    c.pc = 16'h0300;
    c.ilen = 3'h3;
    c.operand = 16'h4000;
    c.sp = 16'h8000;
    slow <= 1'b1;
    run();
    chk("call pc", 24'h004000, r.pc);
    chk("push", 24'h000303, m.mem_r[8'hff]);
    c.op = OP_RETURN;
    c.sp = 16'h7ffe;
    run();
    chk("return", 24'h038000, {r.pc[7:0], r.sp});
    m.mem_r[8'h80] = 16'h4000;
    m.mem_r[8'h81] = 16'h2000;
    c.op = OP_OSCALL;
    run();
    chk("oscall msr", 24'h014000, {r.msr_we, r.msr});
    chk("oscall pc", 24'h002000, r.pc);
    $display("stack test done");
  endtask
  task automatic t_port();
    c = '0;
    c.op = OP_IN;
    c.b = 8'h12;
    c.c = 8'h34;
    c.io_page = 8'h21;
    run();
    chk("in addr", 24'h211234, last_p.addr);
    chk("in data", 24'h0001f7, {r.reg_we, r.reg_data});
    chk("in flags", 24'h000080, r.flags & 8'hd6);
    c.op = OP_PTEST;
    run();
    chk("tst we", 24'h000001, {r.reg_we, r.flags_we});
    c.op = OP_WOUT;
    c.hl = 16'habcd;
    run();
    chk("word out", 24'h00cdab, last_p.wdata);
    k = n_ext;
    c.op = OP_OUT;
    c.src = 8'h5e;
    c.io_page = PAGE_CHIP_HI;
    run();
    chk("chip ext", 24'h0, n_ext - k);
    chk("chip data", 24'h00005e, last_p.wdata);
    k = n_ack;
    c.user_mode = 1'b1;
    c.io_inhibit = 1'b1;
    run();
    chk("trap", 24'h000001, n_ack - k + r.trap);
    c.io_inhibit = 1'b0;
    c.op = OP_BLKIN;
    c.b = 8'h02;
    c.rpt = 1'b1;
    c.io_page = 8'h21;
    run();
    chk("blk addr", 24'h210034, last_p.addr);
    chk("blk cnt", 24'h000002, n_ack - k);
    chk("blk hl", 24'h00abcf, r.hl);
    k = n_ack;
    c.pc = 16'h0240;
    c.ilen = 3'h2;
    irq <= 1'b1;
    run();
    chk("blk irq", 24'h010240, {r.resume, r.pc});
    chk("irq acks", 24'h000001, n_ack - k);
    irq <= 1'b0;
    $display("port test done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    slow = 1'b0;
    irq = 1'b0;
    {num_errors, check_count, n_ext, n_ack} = '0;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_flow();
    t_stack();
    t_port();
    print_verdict();
  end
endmodule
bind pfio_exec pfio_exec_chk #(.DEPTH(DEPTH)) chk (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .cmd_ready_o(cmd_ready_o), .mem_req_o(mem_req_o),
  .mem_ack_i(mem_ack_i), .port_req_o(port_req_o),
  .port_ack_i(port_ack_i), .done_o(done_o));
